//--- logic/hlt_timer.sv
// hardware limit timer core: prescaler, counter, modes, postscaler, pwm drive
`timescale 1ns/1ps
// Notes on behaviour
// - interrupt fires when postscaler reaches the selected ratio, 1:1 up to 1:16
// - interrupt output is gated by timer_irq_enable
// - software gate: count while run_enable set, hold while clear
// - at count equal to period, next timer clock returns to zero
// - hardware gate: 00001 stops while signal high, 00010 while low
// - gated-off time lengthens pwm period, and duty when drive high
// - edge reset modes 00011 any, 00100 rising, 00101 falling clear the count
// - early edge reset restarts pwm pulse after two timer clocks
// - level reset: 00110 resets while low, 00111 while high
// - level reset modes ignore the external signal while run_enable clear
// - level reset clears count two clocks after reset level holds
// - counting and pwm restart two clocks after reset level released
// - pwm drive falls only at compare match or in an unlisted mode; held at its level through level reset
// - 01000 one-shot: period match resets count and clears run_enable
// - software one-shot drive starts with run_enable, ends at compare match
// - edge one-shot 01001 rise, 01010 fall, 01011 any; match clears run
// - edge one-shot needs a fresh edge after run_enable is set again
// - edge one-shot: starting edge raises drive, no raise at period match
// - 01100/01101: first edge starts, later edges reset, resume after two
// - edges ignored until run_enable set; period match clears run_enable
// - starting edge and every reset edge raise the pwm drive
// - postscaler advances per period match, pulses one timer clock
module hlt_timer (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  // software control
  input  wire logic                           run_enable_wr,
  input  wire logic                           run_enable_wdata,
  input  wire logic [hlt_pkg::MODE_W-1:0]     mode_select,
  input  wire logic [hlt_pkg::PSEL_W-1:0]     prescale_select,
  input  wire logic [hlt_pkg::POST_W-1:0]     postscale_select,
  input  wire logic [hlt_pkg::CNT_W-1:0]      period_value,
  input  wire logic [hlt_pkg::CNT_W-1:0]      pulse_width_compare,
  input  wire logic                           timer_irq_enable,
  // external reset pin
  input  wire logic                           ext_reset_signal,
  // status
  output logic                                run_enable,
  output logic [hlt_pkg::CNT_W-1:0]           count_value,
  // time base outputs
  output logic                                timer_tick,
  output logic                                postscaled_out,
  output logic                                timer_irq,
  output logic                                pwm_drive
);

  hlt_ers_if ers_bus ();

  logic [hlt_pkg::PS_W-1:0]   ps_q, ps_d, ps_lim;
  logic [hlt_pkg::CNT_W-1:0]  count_q, count_d;
  logic [hlt_pkg::POST_W-1:0] post_q, post_d;
  logic [hlt_pkg::DLY_W-1:0]  dly_q, dly_d, lvl_q, lvl_d;
  logic                       on_q, on_d, armed_q, armed_d, pwm_q, pwm_d;
  logic                       posts_q, posts_d, start_q, start_d;
  logic                       tick, want, go, match, edge_hit, rst_lvl;
  logic                       use_rise, use_fall, stop_high, lvl_high;
  hlt_pkg::hlt_class_t        cls;

  // ----------------------------------------------------------------
  // external signal synchroniser
  // ----------------------------------------------------------------
  hlt_ers_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (ext_reset_signal),
    .ers     (ers_bus.sync)
  );

  assign ers_bus.take = tick;

  // ----------------------------------------------------------------
  // prescaler, one-cycle timer clock enable
  // ----------------------------------------------------------------
  always_comb begin
    ps_lim = hlt_pkg::PS_W'((8'h01 << prescale_select) - 8'h01);
    tick   = (ps_q >= ps_lim);
    ps_d   = tick ? hlt_pkg::PS_RST : ps_q + hlt_pkg::PS_ONE;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ps_q <= hlt_pkg::PS_RST;
    end else begin
      ps_q <= ps_d;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    cls       = hlt_pkg::HLT_NONE;
    use_rise  = 1'b0;
    use_fall  = 1'b0;
    stop_high = 1'b0;
    lvl_high  = 1'b0;
    case (mode_select)
      hlt_pkg::MODE_SW_GATE: cls = hlt_pkg::HLT_SWGATE;
      hlt_pkg::MODE_GATE_HI: begin
        cls       = hlt_pkg::HLT_GATE;
        stop_high = 1'b1;
      end
      hlt_pkg::MODE_GATE_LO: cls = hlt_pkg::HLT_GATE;
      hlt_pkg::MODE_EDGE_ANY: begin
        cls      = hlt_pkg::HLT_EDGE_RST;
        use_rise = 1'b1;
        use_fall = 1'b1;
      end
      hlt_pkg::MODE_EDGE_RISE: begin
        cls      = hlt_pkg::HLT_EDGE_RST;
        use_rise = 1'b1;
      end
      hlt_pkg::MODE_EDGE_FALL: begin
        cls      = hlt_pkg::HLT_EDGE_RST;
        use_fall = 1'b1;
      end
      hlt_pkg::MODE_LVL_LO: cls = hlt_pkg::HLT_LVL_RST;
      hlt_pkg::MODE_LVL_HI: begin
        cls      = hlt_pkg::HLT_LVL_RST;
        lvl_high = 1'b1;
      end
      hlt_pkg::MODE_OS_SW: cls = hlt_pkg::HLT_OS_SW;
      hlt_pkg::MODE_OS_RISE: begin
        cls      = hlt_pkg::HLT_OS_EDGE;
        use_rise = 1'b1;
      end
      hlt_pkg::MODE_OS_FALL: begin
        cls      = hlt_pkg::HLT_OS_EDGE;
        use_fall = 1'b1;
      end
      hlt_pkg::MODE_OS_ANY: begin
        cls      = hlt_pkg::HLT_OS_EDGE;
        use_rise = 1'b1;
        use_fall = 1'b1;
      end
      hlt_pkg::MODE_EHL_RISE: begin
        cls      = hlt_pkg::HLT_OS_EHL;
        use_rise = 1'b1;
      end
      hlt_pkg::MODE_EHL_FALL: begin
        cls      = hlt_pkg::HLT_OS_EHL;
        use_fall = 1'b1;
      end
      default: cls = hlt_pkg::HLT_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // counter, run bit, pwm drive and postscaler next state
  // ----------------------------------------------------------------
  always_comb begin
    edge_hit = (use_rise && ers_bus.rise) || (use_fall && ers_bus.fall);
    rst_lvl  = (ers_bus.level == lvl_high);
    match    = (count_q == period_value);
    count_d  = count_q;
    on_d     = on_q;
    armed_d  = armed_q;
    dly_d    = dly_q;
    lvl_d    = lvl_q;
    pwm_d    = pwm_q;
    post_d   = post_q;
    posts_d  = posts_q;
    start_d  = start_q;
    want     = 1'b0;
    go       = 1'b0;
    if (tick) begin
      posts_d = 1'b0;
      start_d = 1'b0;
      if (dly_q != hlt_pkg::DLY_NONE) begin
        dly_d = dly_q - hlt_pkg::DLY_ONE;
        if (dly_q == hlt_pkg::DLY_LAST && cls != hlt_pkg::HLT_OS_EHL) begin
          pwm_d = 1'b1;
        end
      end
      case (cls)
        hlt_pkg::HLT_SWGATE: want = on_q;
        hlt_pkg::HLT_GATE: want = on_q && (ers_bus.level != stop_high);
        hlt_pkg::HLT_EDGE_RST: begin
          if (on_q && edge_hit) begin
            count_d = hlt_pkg::CNT_RST;
            dly_d   = hlt_pkg::RESTART_TICKS;
          end else begin
            want = on_q;
          end
        end
        hlt_pkg::HLT_LVL_RST: begin
          if (on_q) begin
            if (rst_lvl && lvl_q == hlt_pkg::LEVEL_TICKS) begin
              count_d = hlt_pkg::CNT_RST;
            end else if (rst_lvl) begin
              lvl_d = lvl_q + hlt_pkg::DLY_ONE;
              want  = 1'b1;
            end else if (lvl_q == hlt_pkg::LEVEL_TICKS) begin
              lvl_d = hlt_pkg::DLY_NONE;
              dly_d = hlt_pkg::RESTART_TICKS;
            end else begin
              lvl_d = hlt_pkg::DLY_NONE;
              want  = 1'b1;
            end
          end
        end
        hlt_pkg::HLT_OS_SW: begin
          want = on_q;
          if (start_q) begin
            pwm_d = 1'b1;
          end
        end
        hlt_pkg::HLT_OS_EDGE: begin
          if (!on_q) begin
            armed_d = 1'b0;
          end else if (!armed_q && edge_hit) begin
            armed_d = 1'b1;
            pwm_d   = 1'b1;
          end
          want = on_q && armed_q;
        end
        hlt_pkg::HLT_OS_EHL: begin
          if (!on_q) begin
            armed_d = 1'b0;
          end else if (edge_hit && !armed_q) begin
            armed_d = 1'b1;
            pwm_d   = 1'b1;
          end else if (edge_hit) begin
            count_d = hlt_pkg::CNT_RST;
            dly_d   = hlt_pkg::RESTART_TICKS;
            pwm_d   = 1'b1;
          end else begin
            want = armed_q;
          end
        end
        default: begin
          count_d = hlt_pkg::CNT_RST;
          pwm_d   = 1'b0;
        end
      endcase
      go = want && (dly_q == hlt_pkg::DLY_NONE);
      if (go) begin
        if (count_q == pulse_width_compare) begin
          pwm_d = 1'b0;
        end
        if (match) begin
          count_d = hlt_pkg::CNT_RST;
          if (cls == hlt_pkg::HLT_OS_SW || cls == hlt_pkg::HLT_OS_EDGE ||
              cls == hlt_pkg::HLT_OS_EHL) begin
            on_d    = 1'b0;
            armed_d = 1'b0;
          end else begin
            pwm_d = 1'b1;
          end
          if (post_q >= postscale_select) begin
            post_d  = hlt_pkg::POST_RST;
            posts_d = 1'b1;
          end else begin
            post_d = post_q + hlt_pkg::POST_ONE;
          end
        end else begin
          count_d = count_q + hlt_pkg::CNT_ONE;
        end
      end
    end
    if (run_enable_wr) begin
      on_d = run_enable_wdata;
      if (run_enable_wdata && !on_q) begin
        start_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= hlt_pkg::CNT_RST;
      on_q    <= 1'b0;
      armed_q <= 1'b0;
      dly_q   <= hlt_pkg::DLY_NONE;
      lvl_q   <= hlt_pkg::DLY_NONE;
      pwm_q   <= 1'b0;
      post_q  <= hlt_pkg::POST_RST;
      posts_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      count_q <= count_d;
      on_q    <= on_d;
      armed_q <= armed_d;
      dly_q   <= dly_d;
      lvl_q   <= lvl_d;
      pwm_q   <= pwm_d;
      post_q  <= post_d;
      posts_q <= posts_d;
      start_q <= start_d;
    end
  end

  assign run_enable     = on_q;
  assign count_value    = count_q;
  assign timer_tick     = tick;
  assign postscaled_out = posts_q;
  assign timer_irq      = posts_q && timer_irq_enable;
  assign pwm_drive      = pwm_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence edge_reset_s;
    tick && cls == hlt_pkg::HLT_EDGE_RST && on_q && edge_hit;
  endsequence

  period_wrap_a: assert property (tick && go && match |=> count_q == hlt_pkg::CNT_RST)
    else $error("count did not wrap after period match");
  sw_gate_a: assert property (tick && cls == hlt_pkg::HLT_SWGATE && !on_q
                              |=> $stable(count_q))
    else $error("count moved with run bit clear");
  hw_gate_a: assert property (tick && mode_select == hlt_pkg::MODE_GATE_HI
                              && ers_bus.level |=> $stable(count_q))
    else $error("count moved while gated off");
  edge_restart_a: assert property (edge_reset_s |=> count_q == hlt_pkg::CNT_RST
                                   && dly_q == hlt_pkg::RESTART_TICKS)
    else $error("edge reset did not start restart delay");
  level_ignore_a: assert property (tick && cls == hlt_pkg::HLT_LVL_RST && !on_q
                                   |=> $stable(count_q))
    else $error("level mode acted with run bit clear");
  oneshot_clear_a: assert property (tick && go && match && cls == hlt_pkg::HLT_OS_SW
                                    && !run_enable_wr |=> !on_q)
    else $error("one-shot did not clear run bit");
  irq_gate_a: assert property (timer_irq |-> timer_irq_enable && post_q == hlt_pkg::POST_RST)
    else $error("interrupt raised while disabled");
  post_pulse_a: assert property ($rose(posts_q) |-> $past(tick) && $past(match))
    else $error("postscaled pulse without period match");
  bad_mode_a: assert property (tick && cls == hlt_pkg::HLT_NONE
                               |=> !pwm_q && count_q == hlt_pkg::CNT_RST)
    else $error("reserved mode left timer running");

endmodule

//--- logic/hlt_pkg.sv
// constants and types for the hardware limit timer
package hlt_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W  = 8;
  localparam int MODE_W = 5;
  localparam int PSEL_W = 3;
  localparam int POST_W = 4;
  localparam int PS_W   = 7;
  localparam int DLY_W  = 2;

  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_SW_GATE   = 5'h00;
  localparam logic [MODE_W-1:0] MODE_GATE_HI   = 5'h01;
  localparam logic [MODE_W-1:0] MODE_GATE_LO   = 5'h02;
  localparam logic [MODE_W-1:0] MODE_EDGE_ANY  = 5'h03;
  localparam logic [MODE_W-1:0] MODE_EDGE_RISE = 5'h04;
  localparam logic [MODE_W-1:0] MODE_EDGE_FALL = 5'h05;
  localparam logic [MODE_W-1:0] MODE_LVL_LO    = 5'h06;
  localparam logic [MODE_W-1:0] MODE_LVL_HI    = 5'h07;
  localparam logic [MODE_W-1:0] MODE_OS_SW     = 5'h08;
  localparam logic [MODE_W-1:0] MODE_OS_RISE   = 5'h09;
  localparam logic [MODE_W-1:0] MODE_OS_FALL   = 5'h0a;
  localparam logic [MODE_W-1:0] MODE_OS_ANY    = 5'h0b;
  localparam logic [MODE_W-1:0] MODE_EHL_RISE  = 5'h0c;
  localparam logic [MODE_W-1:0] MODE_EHL_FALL  = 5'h0d;

  // ----------------------------------------------------------------
  // timing in timer clocks and reset values
  // ----------------------------------------------------------------
  localparam logic [DLY_W-1:0]  RESTART_TICKS = 2'h2;
  localparam logic [DLY_W-1:0]  LEVEL_TICKS   = 2'h2;
  localparam logic [DLY_W-1:0]  DLY_LAST      = 2'h1;
  localparam logic [DLY_W-1:0]  DLY_NONE      = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_RST       = 8'h00;
  localparam logic [POST_W-1:0] POST_RST      = 4'h0;
  localparam logic [PS_W-1:0]   PS_RST        = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 8'h01;
  localparam logic [POST_W-1:0] POST_ONE      = 4'h1;
  localparam logic [PS_W-1:0]   PS_ONE        = 7'h01;
  localparam logic [DLY_W-1:0]  DLY_ONE       = 2'h1;

  // ----------------------------------------------------------------
  // mode classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HLT_SWGATE,
    HLT_GATE,
    HLT_EDGE_RST,
    HLT_LVL_RST,
    HLT_OS_SW,
    HLT_OS_EDGE,
    HLT_OS_EHL,
    HLT_NONE
  } hlt_class_t;

endpackage

//--- logic/hlt_ers_if.sv
// external reset signal carrier between synchroniser and timer core
`timescale 1ns/1ps
interface hlt_ers_if;
  logic level;
  logic rise;
  logic fall;
  logic take;

  modport sync (output level, output rise, output fall, input take);
  modport core (input level, input rise, input fall, output take);
endinterface

//--- logic/hlt_ers_sync.sv
// external reset pin synchroniser with held edge flags
`timescale 1ns/1ps
module hlt_ers_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin
  input wire logic pin_in,
  // to core
  hlt_ers_if.sync  ers
);

  logic s1_q, s2_q, s3_q;
  logic ok1_q, ok2_q, ok3_q;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  // ----------------------------------------------------------------
  // edge flags, held until taken; a new edge wins over take
  // no flags until the chain holds real pin samples after reset
  // ----------------------------------------------------------------
  always_comb begin
    rise_d = (rise_q && !ers.take) || (ok3_q && s2_q && !s3_q);
    fall_d = (fall_q && !ers.take) || (ok3_q && !s2_q && s3_q);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      ok1_q  <= 1'b0;
      ok2_q  <= 1'b0;
      ok3_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      ok1_q  <= 1'b1;
      ok2_q  <= ok1_q;
      ok3_q  <= ok2_q;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign ers.level = s2_q;
  assign ers.rise  = rise_q;
  assign ers.fall  = fall_q;

endmodule

//--- testbench/hlt_ers_src.sv
// far-side model: external reset signal source
`timescale 1ns/1ps
module hlt_ers_src #(
  parameter int GAP = 8,
  parameter int PER = 10
) (
  // clock
  input  wire logic ref_clk,
  // pin
  output logic      ext_reset_signal
);
  time last_t = 0;

  initial ext_reset_signal = 1'b0;

  // change the pin level, keeping edges spaced and levels held
  task automatic put(input logic v);
    @(posedge ref_clk);
    while ($time - last_t < GAP * PER) @(posedge ref_clk);
    ext_reset_signal <= v;
    last_t = $time;
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the hardware limit timer
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        wr        = 1'b0;
  logic        wdat      = 1'b0;
  logic [4:0]  mode      = 5'h00;
  logic [2:0]  psel      = 3'h0;
  logic [3:0]  osel      = 4'h0;
  logic [7:0]  per       = 8'h00;
  logic [7:0]  cmp       = 8'h00;
  logic        ien       = 1'b0;
  logic        ers;
  logic        run;
  logic        tick;
  logic        posts;
  logic        irq;
  logic        pwm;
  logic [7:0]  cnt;
  int          err_total = 0;
  int          tests_run = 0;
  logic [31:0] rnd       = 32'hc7e4_d807;

  always #5 ref_clk = ~ref_clk;

  hlt_timer u_dut (.ref_clk(ref_clk), .rst(rst), .run_enable_wr(wr), .run_enable_wdata(wdat),
    .mode_select(mode), .prescale_select(psel), .postscale_select(osel),
    .period_value(per), .pulse_width_compare(cmp), .timer_irq_enable(ien),
    .ext_reset_signal(ers), .run_enable(run), .count_value(cnt), .timer_tick(tick),
    .postscaled_out(posts), .timer_irq(irq), .pwm_drive(pwm));

  hlt_ers_src #(.GAP(8), .PER(10)) u_src (.ref_clk(ref_clk), .ext_reset_signal(ers));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic setrun(input logic v);
    @(posedge ref_clk);
    wr   <= 1'b1;
    wdat <= v;
    @(posedge ref_clk);
    wr   <= 1'b0;
  endtask

  task automatic start(input logic [4:0] m, input logic [7:0] p, input logic [7:0] c,
                       input logic on);
    @(posedge ref_clk);
    rst  <= 1'b1;
    wr   <= 1'b0;
    mode <= m;
    per  <= p;
    cmp  <= c;
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    if (on) setrun(1'b1);
  endtask

  // random run writes in software gate mode against the model
  task automatic t_swgate();
    int   mc, mp, mpw, mpo, mper, mcmp;
    logic mr, pw, pd, w, d;
    for (int r = 0; r < 3; r++) begin
      rnd = lfsr(rnd);
      mper = 1 + rnd[2:0];
      mcmp = rnd[10:8] % mper;
      start(5'h00, mper[7:0], mcmp[7:0], 1'b0);
      osel <= (r == 0) ? 4'h0 : (r == 1) ? rnd[15:12] : 4'hf;
      mc = 0;
      mp = 0;
      mpw = 0;
      mr = 1'b0;
      pw = 1'b0;
      pd = 1'b0;
      for (int i = 0; i < 250; i++) begin
        rnd = lfsr(rnd);
        w = (rnd[2:0] == 3'h0);
        d = rnd[3] | rnd[4];
        @(posedge ref_clk);
        mpo = 0;
        if (mr) begin
          if (mc == mper) begin
            mc = 0;
            mpw = 1;
            mpo = (mp >= osel);
            mp = mpo ? 0 : mp + 1;
          end else begin
            if (mc == mcmp) mpw = 0;
            mc++;
          end
        end
        if (pw) mr = pd;
        pw = w;
        pd = d;
        wr <= w;
        wdat <= d;
        ien <= rnd[5];
        #1;
        chk(cnt, mc[7:0]);
        chk(run, mr);
        chk(posts, mpo[0]);
        chk(irq, mpo[0] & ien);
        chk(pwm, mpw[0]);
      end
    end
    $display("test software gate done");
  endtask

  // hardware gate stops the count at the chosen level
  task automatic t_gate();
    logic [7:0] c0;
    logic       sl;
    for (int m = 1; m < 3; m++) begin
      sl = (m == 1);
      start(m[4:0], 8'hc8, 8'h64, 1'b1);
      u_src.put(~sl);
      cyc(8);
      chk(cnt > 8'h00, 1'b1);
      u_src.put(sl);
      cyc(6);
      c0 = cnt;
      cyc(5);
      chk(cnt, c0);
      u_src.put(~sl);
      cyc(8);
      chk(cnt > c0, 1'b1);
    end
    $display("test hardware gate done");
  endtask

  // edge reset by direction, pwm restarted after the reset
  task automatic t_edge();
    logic [7:0] c0;
    logic       v, hit, ph;
    for (int m = 3; m < 6; m++) begin
      start(m[4:0], 8'hc8, 8'h64, 1'b1);
      ph = 1'b0;
      for (int t = 0; t < 2; t++) begin
        v = ~ers;
        hit = (v && m != 5) || (!v && m != 4);
        ph = ph | hit;
        u_src.put(v);
        #1;
        c0 = cnt;
        cyc(8);
        chk(hit ? (cnt < 8'h05) : (cnt == c0 + 8'h08), 1'b1);
        chk(pwm, ph);
      end
    end
    $display("test edge reset done");
  endtask

  // level reset holds the count, ignored while run is clear
  task automatic t_level();
    logic [7:0] c0;
    logic       rl;
    for (int m = 6; m < 8; m++) begin
      rl = (m == 7);
      start(m[4:0], 8'hc8, 8'h64, 1'b1);
      u_src.put(~rl);
      cyc(10);
      u_src.put(rl);
      cyc(10);
      chk(cnt, 8'h00);
      u_src.put(~rl);
      cyc(8);
      chk(cnt > 8'h00, 1'b1);
      chk(pwm, 1'b1);
      setrun(1'b0);
      #1;
      c0 = cnt;
      u_src.put(rl);
      cyc(10);
      chk(cnt, c0);
    end
    $display("test level reset done");
  endtask

  // software start one-shot with a pause inside the cycle
  task automatic t_oneshot();
    logic [7:0] c0;
    start(5'h08, 8'h05, 8'h03, 1'b1);
    cyc(2);
    chk(pwm, 1'b1);
    cyc(10);
    chk(run, 1'b0);
    chk(cnt, 8'h00);
    chk(pwm, 1'b0);
    setrun(1'b1);
    setrun(1'b0);
    #1;
    c0 = cnt;
    cyc(5);
    chk(cnt, c0);
    chk(pwm, 1'b1);
    setrun(1'b1);
    cyc(12);
    chk(run, 1'b0);
    $display("test software one-shot done");
  endtask

  // edge started one-shot and edge limit one-shot
  task automatic t_edge_os();
    logic sl, ehl;
    for (int m = 9; m < 14; m++) begin
      sl = (m == 9 || m == 11 || m == 12);
      ehl = (m > 11);
      start(m[4:0], 8'h28, 8'h0a, 1'b0);
      u_src.put(sl);
      u_src.put(~sl);
      cyc(6);
      setrun(1'b1);
      cyc(10);
      chk(cnt, 8'h00);
      u_src.put(sl);
      cyc(8);
      chk(cnt > 8'h00, 1'b1);
      chk(pwm, 1'b1);
      u_src.put(~sl);
      u_src.put(sl);
      cyc(8);
      chk(cnt < 8'h06, ehl);
      chk(pwm, ehl);
      cyc(60);
      chk(run, 1'b0);
      chk(cnt, 8'h00);
      chk(pwm, 1'b0);
    end
    $display("test edge one-shot done");
  endtask

  // unlisted mode codes keep everything idle
  task automatic t_resv();
    logic [4:0] m;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      m = 5'h0e + (rnd[4:0] % 5'h12);
      start(m, 8'h05, 8'h02, 1'b1);
      u_src.put(~ers);
      cyc(10);
      chk(cnt, 8'h00);
      chk(pwm, 1'b0);
    end
    $display("test reserved modes done");
  endtask

  // timer clock rate for prescale settings 0 to 3
  task automatic t_presc();
    int k;
    for (int n = 0; n < 4; n++) begin
      @(posedge ref_clk);
      psel <= n[2:0];
      cyc(130);
      k = 0;
      repeat (64) begin
        k += (tick === 1'b1);
        cyc(1);
      end
      chk(k[15:0], 16'(64 >> n));
    end
    $display("test prescaler done");
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_swgate();
    t_gate();
    t_edge();
    t_level();
    t_oneshot();
    t_edge_os();
    t_resv();
    t_presc();
    end_sim();
  end
endmodule
